// ==== bench/tb.sv ====
// self-checking bench for the two-wire master transmitter
// assumes the slave model on the far side and pull-ups on both lines
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr_s = 1'b0;
    logic       rd_s = 1'b0;
    logic       ack_en = 1'b1;
    logic       stretch = 1'b0;
    logic       contend = 1'b0;
    logic       ce = 1'b1;
    logic       m_scl, m_sda;
    logic [7:0] rdata, last_byte, stops, v, b;
    logic       m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, master_rx, slave_idle;
    wire        scl = !(m_scl_oe || s_scl_oe);
    wire        sda = !(m_sda_oe || s_sda_oe);
    int         error_cnt = 0;
    int         tests_run = 0;
    int         cycles = 0;
    integer     seed = 32'h89b7;
    always #50 clk = ~clk;
    two_wire_master_transmitter i_two_wire_master_transmitter (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_SCL(scl), .O_SCL(m_scl),
        .O_SCL_OE(m_scl_oe), .I_SDA(sda), .O_SDA(m_sda), .O_SDA_OE(m_sda_oe),
        .O_MASTER_RX(master_rx), .O_SLAVE_IDLE(slave_idle));
    two_wire_slave_model i_two_wire_slave_model (
        .scl(scl), .sda(sda), .ack_en(ack_en), .stretch(stretch), .contend(contend),
        .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .last_byte(last_byte), .stops(stops));
    // ==========================================================
    // register port tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    // bounded poll; a byte with stretching needs about 1000 cycles
    task automatic poll(input int k, input logic val);
        for (int n = 0; n < 1500; n++) begin
            rd(two_wire_pkg::ADDR_CTRL);
            if (v[k] === val) break;
        end
        chk({7'h00, v[k]}, {7'h00, val});
    endtask
    task automatic xfer(input logic load, input logic [7:0] d, input logic [7:0] c,
                        input logic [7:0] exp);
        if (load) wr(two_wire_pkg::ADDR_DATA, d);
        wr(two_wire_pkg::ADDR_CTRL, c);
        poll(two_wire_pkg::B_FLAG, 1'b1);
        rd(two_wire_pkg::ADDR_STAT);
        chk(v, exp);
    endtask
    function automatic logic [7:0] exp_code(input logic is_addr, input logic ack);
        if (is_addr) return ack ? two_wire_pkg::CODE_SLAW_ACK : two_wire_pkg::CODE_SLAW_NACK;
        return ack ? two_wire_pkg::CODE_DATA_ACK : two_wire_pkg::CODE_DATA_NACK;
    endfunction
    task automatic end_of_test;
        if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rd(two_wire_pkg::ADDR_STAT);
        chk(v, two_wire_pkg::CODE_IDLE);
        rd(two_wire_pkg::ADDR_CTRL);
        chk(v, two_wire_pkg::RESET_BYTE);
        rd(2'h3);
        chk(v, 8'h00);
        wr(two_wire_pkg::ADDR_DATA, 8'h55);
        rd(two_wire_pkg::ADDR_CTRL);
        chk(v & 8'h08, 8'h08);
        xfer(1'b0, 8'h00, 8'ha4, two_wire_pkg::CODE_START);
        chk({7'h00, m_scl_oe}, 8'h01);
        chk({6'h00, m_scl, m_sda}, 8'h00);
        // a resume written while the clock enable is low must not reach the block
        @(posedge clk) ce <= 1'b0;
        wr(two_wire_pkg::ADDR_CTRL, 8'h84);
        @(posedge clk) ce <= 1'b1;
        rd(two_wire_pkg::ADDR_CTRL);
        chk(v & 8'h80, 8'h80);
        b = 8'($random(seed)) & 8'hfe;
        xfer(1'b1, b, 8'h84, exp_code(1'b1, 1'b1));
        chk(last_byte, b);
        rd(two_wire_pkg::ADDR_CTRL);
        chk(v & 8'h08, 8'h00);
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? 8'h00 : 8'($random(seed));
            ack_en = (i == 1) ? 1'b0 : 1'($random(seed));
            stretch = 1'($random(seed));
            xfer(1'b1, b, 8'h84, exp_code(1'b0, ack_en));
            chk(last_byte, b);
        end
        stretch = 1'b0;
        xfer(1'b0, 8'h00, 8'ha4, two_wire_pkg::CODE_RSTART);
        ack_en = 1'b0;
        xfer(1'b1, b & 8'hfe, 8'h84, exp_code(1'b1, 1'b0));
        ack_en = 1'b1;
        xfer(1'b0, 8'h00, 8'hb4, two_wire_pkg::CODE_START);
        chk(stops, 8'h01);
        rd(two_wire_pkg::ADDR_CTRL);
        chk(v & 8'h10, 8'h00);
        xfer(1'b0, 8'h00, 8'ha4, two_wire_pkg::CODE_RSTART);
        xfer(1'b1, b | 8'h01, 8'h84, two_wire_pkg::CODE_SLAR_ACK);
        chk({7'h00, master_rx}, 8'h01);
        wr(two_wire_pkg::ADDR_CTRL, 8'h94);
        poll(two_wire_pkg::B_STO, 1'b0);
        chk(stops, 8'h02);
        chk(v & 8'h80, 8'h00);
        xfer(1'b0, 8'h00, 8'ha4, two_wire_pkg::CODE_START);
        contend = 1'b1;
        // msb goes out before the contender joins, the next high bit is lost
        xfer(1'b1, 8'hfe, 8'h84, two_wire_pkg::CODE_ARB_LOST);
        contend = 1'b0;
        wr(two_wire_pkg::ADDR_CTRL, 8'h84);
        for (int n = 0; n < 200 && slave_idle !== 1'b1; n++) @(posedge clk);
        chk({7'h00, slave_idle}, 8'h01);
        end_of_test();
    end
endmodule // tb

// ==== bench/two_wire_slave_model.sv ====
// behavioural slave receiver on the two-wire bus, with a contending master built in
// assumes open-drain wires resolved with pull-ups in the bench
module two_wire_slave_model (
    // bus wires
    input  wire logic       scl,
    input  wire logic       sda,
    // behaviour controls
    input  wire logic       ack_en,
    input  wire logic       stretch,
    input  wire logic       contend,
    // pull-downs and observations
    output logic            scl_oe,
    output logic            sda_oe,
    output logic [7:0]      last_byte,
    output logic [7:0]      stops
);
    timeunit 1ns;
    timeprecision 1ns;
    int         bit_cnt = 0;
    logic [7:0] sr = 8'h00;
    logic       in_frame = 1'b0;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        last_byte = 8'h00;
        stops = 8'h00;
    end
    // ==========================================================
    // framing: start or repeated start restarts the bit count
    always @(negedge sda) if (scl) begin
        in_frame = 1'b1;
        bit_cnt = 0;
    end
    always @(posedge sda) if (scl && in_frame) begin
        in_frame = 1'b0;
        stops = stops + 8'h01;
    end
    // ==========================================================
    // bits taken while the clock line is high, msb first
    always @(posedge scl) if (in_frame) begin
        if (bit_cnt < 8) sr = {sr[6:0], sda};
        if (bit_cnt == 7) last_byte = sr;
        bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
    end
    // sda only changes while the clock line is low, so no false start or stop
    always @(negedge scl) begin
        sda_oe = in_frame && ((bit_cnt == 8 && ack_en) || (bit_cnt < 8 && contend));
        if (stretch) begin
            scl_oe = 1'b1;
            // longer than the master's low phase, so its high phase must wait
            #6000;
            scl_oe = 1'b0;
        end
    end
endmodule // two_wire_slave_model

// ==== verilog/two_wire_master_transmitter.sv ====
// master-transmitter engine of a two-wire serial interface
// assumes open-drain bus wiring outside and a 10 MHz clock; pins arrive unsynchronised
//
// What this block does
// - address sent: done flag, code 18/20/38 (40/48 for a read address)
// - data write only while done; else collision
// - data byte sent: done flag, code 28/30/38
// - stop command: done 1, start 0, stop 1
// - restart command: done 1, start 1, stop 0
// - repeated start reports 10, keeps the bus
// - at 08/10 plain resume sends address byte
// - address-with-read at 10 switches to receive
// - at 18..30 plain resume sends data byte
// - start request there issues repeated start
// - stop request issues stop, clears stop bit
// - start plus stop: stop, start, clear bit
// - after lost arbitration: release or start later
// - start request waits idle bus, reports 08
// - writing one clears done; action follows at once
// - clock line held low while done set, except after lost arbitration
// - prescaler bits of status read zero
module two_wire_master_transmitter (
    // clock, reset, enable
    input  wire logic       I_CLK,
    input  wire logic       I_ARST_N,
    input  wire logic       I_CE,
    // register port
    input  wire logic [1:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    // bus pins
    input  wire logic       I_SCL,
    output logic            O_SCL,
    output logic            O_SCL_OE,
    input  wire logic       I_SDA,
    output logic            O_SDA,
    output logic            O_SDA_OE,
    // mode indications
    output logic            O_MASTER_RX,
    output logic            O_SLAVE_IDLE
);
    // ==========================================================
    // declarations
    two_wire_pkg::state_type state;
    logic       scl_m, scl_s, sda_m, sda_s, sda_d, busy;
    logic       done_flag, ack_en, sta, sto, wc, en, ie;
    logic [7:0] shift;
    logic [4:0] code;
    logic [7:0] tmr;
    logic [1:0] step;
    logic [3:0] bit_cnt;
    logic       rep, first, rd_addr, ack, start_after;
    logic       ctl_wr, data_wr, clr_flag, cmd, stall, step_done, last_step, byte_fin;
    logic       set_done;

    assign ctl_wr = I_CE && I_WR && I_ADDR == two_wire_pkg::ADDR_CTRL;
    assign data_wr = I_CE && I_WR && I_ADDR == two_wire_pkg::ADDR_DATA;
    assign clr_flag = ctl_wr && I_WDATA[two_wire_pkg::B_FLAG];
    // commands are only taken when no bus step is in flight; the enable comes
    // from the write itself so the very first start command is not lost
    assign cmd = clr_flag && I_WDATA[two_wire_pkg::B_EN]
        && (state == two_wire_pkg::S_HOLD || state == two_wire_pkg::S_IDLE
        || state == two_wire_pkg::S_LOST);
    // a slave may stretch the clock: the high phase waits for the line
    assign stall = step == 2'd1 && !scl_s;
    assign step_done = I_CE && !stall && tmr == two_wire_pkg::QUARTER_CYC - 8'h01
        && (state == two_wire_pkg::S_START || state == two_wire_pkg::S_BIT
        || state == two_wire_pkg::S_STOP);
    assign last_step = step_done && step == 2'd3;
    assign byte_fin = last_step && state == two_wire_pkg::S_BIT
        && bit_cnt == two_wire_pkg::LAST_BIT;
    assign set_done = (last_step && state == two_wire_pkg::S_START) || byte_fin
        || (step_done && step == 2'd2 && state == two_wire_pkg::S_BIT
        && bit_cnt != two_wire_pkg::LAST_BIT && shift[7] && !sda_s);

    // ==========================================================
    // pin synchronisers and bus busy tracking
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else if (I_CE) begin
            scl_m <= I_SCL;
            scl_s <= scl_m;
            sda_m <= I_SDA;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            busy <= 1'b0;
        end else if (I_CE) begin
            if (!en) begin
                busy <= 1'b0;
            end else if (scl_s && sda_d && !sda_s) begin
                busy <= 1'b1;
            end else if (scl_s && !sda_d && sda_s) begin
                busy <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            done_flag <= 1'b0;
            ack_en <= 1'b0;
            sta <= 1'b0;
            sto <= 1'b0;
            en <= 1'b0;
            ie <= 1'b0;
            wc <= 1'b0;
        end else if (I_CE) begin
            // a hardware set wins over a clear in the same cycle
            done_flag <= set_done || (done_flag && !clr_flag);
            if (ctl_wr) begin
                ack_en <= I_WDATA[two_wire_pkg::B_ACKEN];
                sta <= I_WDATA[two_wire_pkg::B_STA];
                sto <= I_WDATA[two_wire_pkg::B_STO];
                en <= I_WDATA[two_wire_pkg::B_EN];
                ie <= I_WDATA[two_wire_pkg::B_IE];
            end else if (last_step && state == two_wire_pkg::S_STOP) begin
                sto <= 1'b0;
            end
            if (data_wr && !done_flag) begin
                wc <= 1'b1;
            end else if (data_wr) begin
                wc <= 1'b0;
            end
        end
    end

    // ==========================================================
    // data / shift register
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            shift <= two_wire_pkg::RESET_BYTE;
        end else if (I_CE) begin
            if (data_wr && done_flag) begin
                shift <= I_WDATA;
            end else if (last_step && state == two_wire_pkg::S_BIT
                && bit_cnt != two_wire_pkg::LAST_BIT) begin
                shift <= {shift[6:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state <= two_wire_pkg::S_IDLE;
            tmr <= 8'h00;
            step <= 2'd0;
            bit_cnt <= 4'h0;
            rep <= 1'b0;
            first <= 1'b0;
            rd_addr <= 1'b0;
            ack <= 1'b0;
            start_after <= 1'b0;
        end else if (I_CE) begin
            if (step_done) begin
                tmr <= 8'h00;
                step <= step + 2'd1;
            end else if (state == two_wire_pkg::S_START || state == two_wire_pkg::S_BIT
                || state == two_wire_pkg::S_STOP) begin
                if (!stall) begin
                    tmr <= tmr + 8'h01;
                end
            end else begin
                tmr <= 8'h00;
                step <= 2'd0;
            end
            if (!en && !cmd) begin
                state <= two_wire_pkg::S_IDLE;
            end else begin
                case (state)
                    two_wire_pkg::S_IDLE: begin
                        if (cmd && I_WDATA[two_wire_pkg::B_STA]) begin
                            state <= two_wire_pkg::S_WAIT;
                        end
                    end
                    two_wire_pkg::S_LOST: begin
                        if (cmd && I_WDATA[two_wire_pkg::B_STA]) begin
                            state <= two_wire_pkg::S_WAIT;
                        end else if (cmd) begin
                            state <= two_wire_pkg::S_IDLE;
                        end
                    end
                    two_wire_pkg::S_WAIT: begin
                        if (!busy) begin
                            state <= two_wire_pkg::S_START;
                            rep <= 1'b0;
                        end
                    end
                    two_wire_pkg::S_HOLD: begin
                        if (cmd && I_WDATA[two_wire_pkg::B_STO]) begin
                            state <= two_wire_pkg::S_STOP;
                            start_after <= I_WDATA[two_wire_pkg::B_STA];
                        end else if (cmd && I_WDATA[two_wire_pkg::B_STA]) begin
                            state <= two_wire_pkg::S_START;
                            rep <= 1'b1;
                        end else if (cmd) begin
                            state <= two_wire_pkg::S_BIT;
                            bit_cnt <= 4'h0;
                            if (first) begin
                                rd_addr <= shift[0];
                            end
                        end
                    end
                    two_wire_pkg::S_START: begin
                        if (last_step) begin
                            state <= two_wire_pkg::S_HOLD;
                            first <= 1'b1;
                        end
                    end
                    two_wire_pkg::S_STOP: begin
                        if (last_step) begin
                            state <= start_after ? two_wire_pkg::S_START
                                                 : two_wire_pkg::S_IDLE;
                            rep <= 1'b0;
                        end
                    end
                    two_wire_pkg::S_BIT: begin
                        if (set_done && !byte_fin) begin
                            state <= two_wire_pkg::S_LOST;
                        end else if (step_done && step == 2'd2
                            && bit_cnt == two_wire_pkg::LAST_BIT) begin
                            ack <= !sda_s;
                        end else if (byte_fin) begin
                            state <= two_wire_pkg::S_HOLD;
                            first <= 1'b0;
                        end else if (last_step) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    default: begin
                        state <= two_wire_pkg::S_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // status code
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            code <= two_wire_pkg::CODE_IDLE[7:3];
        end else if (I_CE) begin
            if (!en || (last_step && state == two_wire_pkg::S_STOP)) begin
                code <= two_wire_pkg::CODE_IDLE[7:3];
            end else if (last_step && state == two_wire_pkg::S_START) begin
                code <= rep ? two_wire_pkg::CODE_RSTART[7:3]
                            : two_wire_pkg::CODE_START[7:3];
            end else if (set_done && !byte_fin) begin
                code <= two_wire_pkg::CODE_ARB_LOST[7:3];
            end else if (byte_fin && first && rd_addr) begin
                code <= ack ? two_wire_pkg::CODE_SLAR_ACK[7:3]
                            : two_wire_pkg::CODE_SLAR_NACK[7:3];
            end else if (byte_fin && first) begin
                code <= ack ? two_wire_pkg::CODE_SLAW_ACK[7:3]
                            : two_wire_pkg::CODE_SLAW_NACK[7:3];
            end else if (byte_fin) begin
                code <= ack ? two_wire_pkg::CODE_DATA_ACK[7:3]
                            : two_wire_pkg::CODE_DATA_NACK[7:3];
            end
        end
    end

    // ==========================================================
    // pin drivers and mode outputs, all registered
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_SCL <= 1'b0;
            O_SDA <= 1'b0;
            O_SCL_OE <= 1'b0;
            O_SDA_OE <= 1'b0;
        end else if (I_CE) begin
            O_SCL <= 1'b0;
            O_SDA <= 1'b0;
            case (state)
                two_wire_pkg::S_START: begin
                    O_SCL_OE <= step == 2'd3 || (step == 2'd0 && O_SCL_OE);
                    O_SDA_OE <= step >= 2'd2;
                end
                two_wire_pkg::S_STOP: begin
                    O_SCL_OE <= step == 2'd0;
                    O_SDA_OE <= step <= 2'd1;
                end
                two_wire_pkg::S_BIT: begin
                    O_SCL_OE <= step == 2'd0 || step == 2'd3;
                    O_SDA_OE <= bit_cnt != two_wire_pkg::LAST_BIT && !shift[7];
                end
                two_wire_pkg::S_HOLD: begin
                    O_SCL_OE <= 1'b1;
                    O_SDA_OE <= O_SDA_OE;
                end
                default: begin
                    O_SCL_OE <= 1'b0;
                    O_SDA_OE <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_MASTER_RX <= 1'b0;
            O_SLAVE_IDLE <= 1'b0;
        end else if (I_CE) begin
            if (!en || state == two_wire_pkg::S_START || state == two_wire_pkg::S_STOP) begin
                O_MASTER_RX <= 1'b0;
            end else if (byte_fin && first && rd_addr) begin
                O_MASTER_RX <= 1'b1;
            end
            if (!en || state == two_wire_pkg::S_WAIT) begin
                O_SLAVE_IDLE <= 1'b0;
            end else if (cmd && state == two_wire_pkg::S_LOST) begin
                O_SLAVE_IDLE <= !I_WDATA[two_wire_pkg::B_STA];
            end
        end
    end

    // ==========================================================
    // read port: data one cycle after the strobe
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RDATA <= 8'h00;
        end else if (I_CE) begin
            if (I_RD) begin
                case (I_ADDR)
                    two_wire_pkg::ADDR_CTRL: O_RDATA <= {done_flag, ack_en, sta, sto,
                                                         wc, en, 1'b0, ie};
                    two_wire_pkg::ADDR_DATA: O_RDATA <= shift;
                    two_wire_pkg::ADDR_STAT: O_RDATA <= {code, 3'b000};
                    default: O_RDATA <= 8'h00;
                endcase
            end else begin
                O_RDATA <= 8'h00;
            end
        end
    end

    // ==========================================================
    // checks
    a_scl_held: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        $past(state == two_wire_pkg::S_HOLD) && state == two_wire_pkg::S_HOLD |-> O_SCL_OE)
        else $error("clock line not held low while done");
    a_collision_set: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        data_wr && !done_flag && !last_step |=> wc && $stable(shift))
        else $error("data write while busy not refused");
    a_no_op_done: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        done_flag |-> state == two_wire_pkg::S_HOLD || state == two_wire_pkg::S_LOST)
        else $error("bus step running while done set");
    a_resume_byte: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        cmd && state == two_wire_pkg::S_HOLD && !I_WDATA[two_wire_pkg::B_STA]
        && !I_WDATA[two_wire_pkg::B_STO] |=> state == two_wire_pkg::S_BIT && !done_flag)
        else $error("resume did not start byte");
    a_addr_code: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        byte_fin && first && !rd_addr |=> done_flag
        && (code == two_wire_pkg::CODE_SLAW_ACK[7:3] || code == two_wire_pkg::CODE_SLAW_NACK[7:3]))
        else $error("wrong address status");
    a_data_code: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        byte_fin && !first && ack |=> code == two_wire_pkg::CODE_DATA_ACK[7:3])
        else $error("wrong data status");
    a_rstart_code: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        last_step && state == two_wire_pkg::S_START && rep
        |=> code == two_wire_pkg::CODE_RSTART[7:3] && state == two_wire_pkg::S_HOLD)
        else $error("repeated start status wrong");
    a_stop_clear: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        last_step && state == two_wire_pkg::S_STOP && !ctl_wr |=> !sto && !done_flag)
        else $error("stop bit not cleared after stop");
    a_msb_first: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        state == two_wire_pkg::S_BIT && step == 2'd2 && bit_cnt != two_wire_pkg::LAST_BIT
        |-> O_SDA_OE == !shift[7])
        else $error("data bit order wrong");
    a_lost_release: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        state == two_wire_pkg::S_LOST ##1 state == two_wire_pkg::S_LOST
        |-> !O_SDA_OE && !O_SCL_OE && code == two_wire_pkg::CODE_ARB_LOST[7:3])
        else $error("bus not released after lost arbitration");
    a_status_low: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        I_CE && I_RD && I_ADDR == two_wire_pkg::ADDR_STAT |=> O_RDATA[2:0] == 3'h0)
        else $error("status low bits not zero");
endmodule // two_wire_master_transmitter

// ==== verilog/two_wire_pkg.sv ====
// constants, field positions and state type for the two-wire master transmitter
// assumes a 10 MHz system clock and an 8-bit register port
package two_wire_pkg;
    // ==========================================================
    // register offsets
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_DATA = 2'h1;
    localparam logic [1:0] ADDR_STAT = 2'h2;
    // ==========================================================
    // control register fields
    localparam int B_FLAG = 7;
    localparam int B_ACKEN = 6;
    localparam int B_STA = 5;
    localparam int B_STO = 4;
    localparam int B_WC = 3;
    localparam int B_EN = 2;
    localparam int B_IE = 0;
    // ==========================================================
    // status codes, low three bits always zero
    localparam logic [7:0] CODE_START = 8'h08;
    localparam logic [7:0] CODE_RSTART = 8'h10;
    localparam logic [7:0] CODE_SLAW_ACK = 8'h18;
    localparam logic [7:0] CODE_SLAW_NACK = 8'h20;
    localparam logic [7:0] CODE_DATA_ACK = 8'h28;
    localparam logic [7:0] CODE_DATA_NACK = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST = 8'h38;
    localparam logic [7:0] CODE_SLAR_ACK = 8'h40;
    localparam logic [7:0] CODE_SLAR_NACK = 8'h48;
    localparam logic [7:0] CODE_IDLE = 8'hf8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // ==========================================================
    // bus timing: one quarter of a 100 kHz bit
    localparam int CLK_NS = 100;
    localparam int QUARTER_NS = 2500;
    localparam logic [7:0] QUARTER_CYC = 8'((QUARTER_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] LAST_BIT = 4'h8;
    // ==========================================================
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_WAIT  = 3'b001,
        S_START = 3'b010,
        S_BIT   = 3'b011,
        S_STOP  = 3'b100,
        S_HOLD  = 3'b101,
        S_LOST  = 3'b110
    } state_type;
endpackage
